// ===== src/bus_cycle_seq.v
`timescale 1ns/100ps
`include "bus_seq_defs.vh"

// How it works
// - Memory and port cycles take phase_one..three; internal cycles take one idle_state.
// - System clock is the input clock divided by two; one state per period.
// - Stretch states go only between phase_two and phase_three.
// - opcode_fetch_strobe_n is low throughout every op-code fetch with the indicator enabled or forced.
// - Fetch address is driven at the start of phase_one.
// - storage_strobe_n and read_strobe_n fall mid phase_one of a fetch.
// - Fetch data latched at phase_three rise; cycle ends with phase_three.
// - Wait request combines the wait pin and the programmable generator.
// - Wait sampled at phase_two fall; low inserts one stretch state.
// - Address and strobes hold steady during stretch states.
// - Wait resampled each stretch fall; high moves on to phase_three.
// - Reads keep fetch strobe high and latch data at phase_three fall.
// - Writes drop storage_strobe_n mid phase_one, drive data at its end.
// - Write strobe falls at phase_two start; strobes then data release in phase_three.
// - Port cycles use port_strobe_n, untranslated 16-bit address, upper bits low.
// - External port cycles get at least one stretch; internal ones do not.
// - Internal cycles leave the bus idle with no strobes.
// - Reset pin low six clocks aborts and restarts at address zero.
// - bus_grant_n goes low in the same cycle that the bus is released.
// - Bus granted only at machine-cycle boundaries.
// - Released bus: address, data and four strobes tri-stated.
// - No refresh while released; the other master refreshes.
// - Bus request sampled at every fall; the fall inside phase_three, idle and release states decides.
// - Fetch strobe enable and port strobe timing are software selectable.
// - Compat set: port strobes fall mid phase_one; cleared: at phase_two rise.
// - Indicator disabled: fetch strobe only on forced fetches.
module bus_cycle_seq #(
	parameter ADDR_W = 20,
	parameter DATA_W = 8
) (
	input wire mclk,
	input wire rst_n,
	// core side request port
	input wire req_valid,
	input wire [2:0] req_kind,
	input wire [ADDR_W-1:0] req_addr,
	input wire [DATA_W-1:0] req_wdata,
	input wire req_port_internal,
	input wire req_force_indicator,
	output wire req_ready,
	output reg done,
	output reg [DATA_W-1:0] rdata,
	output reg restart,
	// mode and wait settings
	input wire fetch_indicator_enable,
	input wire port_timing_compat,
	input wire [1:0] mem_wait_count,
	input wire [1:0] io_wait_count,
	// pins
	output wire phi,
	input wire reset_pin_n,
	input wire wait_n,
	input wire bus_request_n,
	output reg bus_grant_n,
	output reg [ADDR_W-1:0] addr_out,
	output reg addr_oe,
	input wire [DATA_W-1:0] data_in,
	output reg [DATA_W-1:0] data_out,
	output reg data_oe,
	output reg storage_strobe_n,
	output reg port_strobe_n,
	output reg read_strobe_n,
	output reg data_put_strobe_n,
	output reg strobe_oe,
	output reg opcode_fetch_strobe_n
);

	// ****************************************
	// states, one per system clock
	// ****************************************
	localparam ST_T1 = 3'h0;
	localparam ST_T2 = 3'h1;
	localparam ST_TW = 3'h2;
	localparam ST_T3 = 3'h3;
	localparam ST_TI = 3'h4;
	localparam ST_TX = 3'h5;
	// no cycle pending, so an empty idle state reports nothing
	localparam KIND_IDLE = 3'h7;

	wire rise_en;
	wire fall_en;
	reg [2:0] st;
	reg [2:0] cur_kind;
	reg [1:0] wcnt;
	reg stretch;
	reg breq_seen;
	reg zero_next;
	reg [2:0] rst_cnt;
	reg wait_s1, wait_s;
	reg breq_s1, breq_s;
	reg rstin_s1, rstin_s;
	reg [DATA_W-1:0] din_s1, din_s;
	wire held_long;
	wire boundary;

	// ****************************************
	// helpers
	// ****************************************
	// port cycle test, used in several places
	function is_port;
		input [2:0] k;
		begin
			is_port = (k == `KIND_IO_RD) || (k == `KIND_IO_WR);
		end
	endfunction

	// write cycle test
	function is_write;
		input [2:0] k;
		begin
			is_write = (k == `KIND_MEM_WR) || (k == `KIND_IO_WR);
		end
	endfunction

	// system clock and its edge enables
	phase_gen u_phase (
		.mclk(mclk),
		.rst_n(rst_n),
		.phi(phi),
		.rise_en(rise_en),
		.fall_en(fall_en)
	);

	// ****************************************
	// pin synchronisers
	// ****************************************
	// two stages before any logic reads a pin
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wait_s1 <= 1'b1;
			wait_s <= 1'b1;
			breq_s1 <= 1'b1;
			breq_s <= 1'b1;
			rstin_s1 <= 1'b1;
			rstin_s <= 1'b1;
			din_s1 <= `RST_DATA;
			din_s <= `RST_DATA;
		end else begin
			wait_s1 <= wait_n;
			wait_s <= wait_s1;
			breq_s1 <= bus_request_n;
			breq_s <= breq_s1;
			rstin_s1 <= reset_pin_n;
			rstin_s <= rstin_s1;
			din_s1 <= data_in;
			din_s <= din_s1;
		end
	end

	// ****************************************
	// reset pin qualification
	// ****************************************
	// counts system clocks with the pin low, saturating
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_cnt <= 3'h0;
			restart <= 1'b0;
		end else begin
			restart <= 1'b0;
			if (rstin_s) begin
				restart <= held_long;
				rst_cnt <= 3'h0;
			end else if (rise_en && !held_long) begin
				rst_cnt <= rst_cnt + 3'h1;
			end
		end
	end

	assign held_long = (rst_cnt >= `RESET_MIN_CLOCKS);
	assign boundary = (st == ST_T3) || (st == ST_TI) || (st == ST_TX);
	// requests are taken only at a boundary with the bus kept
	assign req_ready = rise_en && boundary && !breq_seen && !held_long;

	// ****************************************
	// cycle sequencer, steps on both phi edges
	// ****************************************
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= ST_TI;
			cur_kind <= KIND_IDLE;
			wcnt <= 2'h0;
			stretch <= 1'b0;
			breq_seen <= 1'b0;
			zero_next <= 1'b1;
			done <= 1'b0;
			rdata <= `RST_DATA;
			bus_grant_n <= `RST_STROBE;
			addr_out <= `RST_ADDR;
			addr_oe <= 1'b1;
			data_out <= `RST_DATA;
			data_oe <= 1'b0;
			storage_strobe_n <= `RST_STROBE;
			port_strobe_n <= `RST_STROBE;
			read_strobe_n <= `RST_STROBE;
			data_put_strobe_n <= `RST_STROBE;
			strobe_oe <= 1'b1;
			opcode_fetch_strobe_n <= `RST_STROBE;
		end else begin
			done <= 1'b0;
			if (held_long) begin
				// abandon the cycle and idle until released
				st <= ST_TI;
				cur_kind <= KIND_IDLE;
				zero_next <= 1'b1;
				breq_seen <= 1'b0;
				bus_grant_n <= 1'b1;
				addr_oe <= 1'b1;
				strobe_oe <= 1'b1;
				data_oe <= 1'b0;
				storage_strobe_n <= 1'b1;
				port_strobe_n <= 1'b1;
				read_strobe_n <= 1'b1;
				data_put_strobe_n <= 1'b1;
				opcode_fetch_strobe_n <= 1'b1;
			end else if (rise_en) begin
				case (st)
				ST_T1: begin
					st <= ST_T2;
					if (is_write(cur_kind)) begin
						data_oe <= 1'b1;
						data_put_strobe_n <= 1'b0;
					end
					// late port strobes for peripheral timing
					if (is_port(cur_kind) && !port_timing_compat) begin
						port_strobe_n <= 1'b0;
						if (cur_kind == `KIND_IO_RD) begin
							read_strobe_n <= 1'b0;
						end
					end
				end
				ST_T2, ST_TW: begin
					// pins held unchanged while stretching
					if (stretch) begin
						st <= ST_TW;
						if (wcnt != 2'h0) begin
							wcnt <= wcnt - 2'h1;
						end
					end else begin
						st <= ST_T3;
						if (cur_kind == `KIND_FETCH) begin
							rdata <= din_s;
						end
					end
				end
				default: begin
					// close the finished cycle
					if (st == ST_T3) begin
						done <= 1'b1;
						storage_strobe_n <= 1'b1;
						port_strobe_n <= 1'b1;
						read_strobe_n <= 1'b1;
						opcode_fetch_strobe_n <= 1'b1;
						data_oe <= 1'b0;
					end else if (st == ST_TI && cur_kind == `KIND_INTERNAL) begin
						done <= 1'b1;
					end
					cur_kind <= KIND_IDLE;
					if (breq_seen) begin
						// release the bus and grant it in the same cycle
						st <= ST_TX;
						addr_oe <= 1'b0;
						strobe_oe <= 1'b0;
						data_oe <= 1'b0;
						bus_grant_n <= 1'b0;
					end else begin
						bus_grant_n <= 1'b1;
						addr_oe <= 1'b1;
						strobe_oe <= 1'b1;
						if (req_valid) begin
							cur_kind <= req_kind;
							data_out <= req_wdata;
							if (req_kind == `KIND_INTERNAL) begin
								st <= ST_TI;
							end else begin
								st <= ST_T1;
							end
							// address at the start of phase_one
							if (is_port(req_kind)) begin
								addr_out <= {{(ADDR_W-`IO_ADDR_BITS){1'b0}},
									req_addr[`IO_ADDR_BITS-1:0]};
							end else if (req_kind == `KIND_FETCH && zero_next) begin
								addr_out <= `RST_ADDR;
							end else if (req_kind != `KIND_INTERNAL) begin
								addr_out <= req_addr;
							end
							if (req_kind == `KIND_FETCH) begin
								zero_next <= 1'b0;
								opcode_fetch_strobe_n <=
									~(fetch_indicator_enable | req_force_indicator);
							end
							// programmable wait count for this cycle
							if (is_port(req_kind)) begin
								if (req_port_internal) begin
									wcnt <= 2'h0;
								end else if (io_wait_count < `IO_MIN_STRETCH) begin
									wcnt <= `IO_MIN_STRETCH;
								end else begin
									wcnt <= io_wait_count;
								end
							end else begin
								wcnt <= mem_wait_count;
							end
						end else begin
							st <= ST_TI;
						end
					end
				end
				endcase
			end else if (fall_en) begin
				breq_seen <= ~breq_s;
				case (st)
				ST_T1: begin
					if (cur_kind == `KIND_FETCH || cur_kind == `KIND_MEM_RD) begin
						storage_strobe_n <= 1'b0;
						read_strobe_n <= 1'b0;
					end else if (cur_kind == `KIND_MEM_WR) begin
						storage_strobe_n <= 1'b0;
					end else if (is_port(cur_kind) && port_timing_compat) begin
						port_strobe_n <= 1'b0;
						if (cur_kind == `KIND_IO_RD) begin
							read_strobe_n <= 1'b0;
						end
					end
				end
				ST_T2, ST_TW: begin
					// combined wait: pin low or generator still counting
					stretch <= ~wait_s | (wcnt != 2'h0);
				end
				ST_T3: begin
					if (cur_kind == `KIND_MEM_RD || cur_kind == `KIND_IO_RD) begin
						rdata <= din_s;
					end
					if (is_write(cur_kind)) begin
						storage_strobe_n <= 1'b1;
						port_strobe_n <= 1'b1;
						data_put_strobe_n <= 1'b1;
					end
				end
				default: begin
					stretch <= 1'b0;
				end
				endcase
			end
		end
	end

	// ****************************************
	// notes on the released bus
	// ****************************************
	// refresh is not this block's job; while granted nothing
	// touches the bus, so the other master refreshes
	// every sequencer step above sits on a rise or fall enable, except the held_long abort

endmodule // bus_cycle_seq

// ===== pkg/bus_seq_defs.vh
`ifndef BUS_SEQ_DEFS_VH
`define BUS_SEQ_DEFS_VH

// ****************************************
// cycle kinds on the request port
// ****************************************
`define KIND_FETCH 3'h0
`define KIND_MEM_RD 3'h1
`define KIND_MEM_WR 3'h2
`define KIND_IO_RD 3'h3
`define KIND_IO_WR 3'h4
`define KIND_INTERNAL 3'h5

// ****************************************
// timing counts
// ****************************************
// reset pin must stay low this many system clocks
`define RESET_MIN_CLOCKS 3'h6
// least automatic stretch count of an external port cycle
`define IO_MIN_STRETCH 2'h1
// lower address bits kept in port cycles; the bits above are forced low
`define IO_ADDR_BITS 16

// ****************************************
// reset values
// ****************************************
`define RST_STROBE 1'b1
`define RST_ADDR 20'h00000
`define RST_DATA 8'h00

`endif

// ===== src/phase_gen.v
`timescale 1ns/100ps

// ****************************************
// system clock at half the input rate
// ****************************************
module phase_gen (
	input wire mclk,
	input wire rst_n,
	output reg phi,
	output wire rise_en,
	output wire fall_en
);

	// phi toggles every mclk, so each phase lasts one mclk
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			phi <= 1'b0;
		end else begin
			phi <= ~phi;
		end
	end

	// one-cycle enables marking the next phi edge
	assign rise_en = ~phi;
	assign fall_en = phi;

endmodule // phase_gen

// ===== tb/bus_cycle_seq_monitor.sv
`timescale 1ns/100ps
// ****************************************
// bus cycle checker
// ****************************************
module bus_cycle_seq_monitor #(
	parameter ADDR_W = 20,
	parameter DATA_W = 8
) (
	input wire mclk,
	input wire rst_n,
	input wire req_valid,
	input wire [2:0] req_kind,
	input wire [ADDR_W-1:0] req_addr,
	input wire req_port_internal,
	input wire req_ready,
	input wire done,
	input wire fetch_indicator_enable,
	input wire port_timing_compat,
	input wire bus_grant_n,
	input wire [ADDR_W-1:0] addr_out,
	input wire addr_oe,
	input wire data_oe,
	input wire storage_strobe_n,
	input wire port_strobe_n,
	input wire read_strobe_n,
	input wire data_put_strobe_n,
	input wire strobe_oe,
	input wire opcode_fetch_strobe_n
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// request taken and port cycle kinds
	wire take = req_valid && req_ready;
	wire port = req_kind == 3'h3 || req_kind == 3'h4;
	// internal cycle shows no storage or port strobe
	sequence quiet_ti;
		(storage_strobe_n && port_strobe_n) [*2];
	endsequence
	// external port cycle cannot end in three states
	sequence port_long;
		!done [*6];
	endsequence
	AST_INT_QUIET: assert property (take && req_kind == 3'h5 |-> ##1 quiet_ti ##1 done)
		else $error("internal cycle strobed or ran long");
	AST_FETCH_ADDR: assert property (take && req_kind == 3'h0 |=> addr_oe &&
		(addr_out == $past(req_addr) || addr_out == '0)) else $error("fetch address wrong");
	AST_FETCH_LOW: assert property (take && req_kind == 3'h0 && fetch_indicator_enable
		|-> ##1 !opcode_fetch_strobe_n [*5]) else $error("fetch strobe not low");
	AST_READ_HIGH: assert property (take && req_kind == 3'h1 |->
		##1 opcode_fetch_strobe_n [*5]) else $error("fetch strobe low in data read");
	AST_ADDR_HOLD: assert property (!read_strobe_n |=> read_strobe_n || $stable(addr_out))
		else $error("address moved while reading");
	AST_GRANT_FLOAT: assert property (!bus_grant_n |-> !(addr_oe || data_oe || strobe_oe))
		else $error("bus driven while granted");
	AST_PORT_UPPER: assert property (!port_strobe_n && strobe_oe |->
		addr_out[ADDR_W-1:16] == '0) else $error("upper address set in port cycle");
	AST_PUT_DATA: assert property (!data_put_strobe_n && strobe_oe |-> data_oe &&
		!(storage_strobe_n && port_strobe_n)) else $error("write strobe without data");
	AST_PORT_STRETCH: assert property (take && port && !req_port_internal |-> ##2 port_long)
		else $error("port cycle without stretch");
	AST_PORT_TIMING: assert property (take && port && !req_port_internal |->
		##2 (port_strobe_n == !port_timing_compat) ##1 !port_strobe_n) else $error("port strobe timing");
endmodule // bus_cycle_seq_monitor

bind bus_cycle_seq bus_cycle_seq_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mon (
	.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr),
	.req_port_internal(req_port_internal), .req_ready(req_ready), .done(done),
	.fetch_indicator_enable(fetch_indicator_enable), .port_timing_compat(port_timing_compat),
	.bus_grant_n(bus_grant_n), .addr_out(addr_out), .addr_oe(addr_oe), .data_oe(data_oe),
	.storage_strobe_n(storage_strobe_n), .port_strobe_n(port_strobe_n),
	.read_strobe_n(read_strobe_n), .data_put_strobe_n(data_put_strobe_n),
	.strobe_oe(strobe_oe), .opcode_fetch_strobe_n(opcode_fetch_strobe_n));

// ===== tb/bus_partner_model.sv
`timescale 1ns/100ps
// ****************************************
// memory and port device model
// ****************************************
module bus_partner_model (
	input wire mclk,
	input wire [19:0] addr_out,
	input wire read_strobe_n,
	input wire data_put_strobe_n,
	input wire [7:0] data_out,
	input wire [3:0] stall,
	output wire [7:0] data_in,
	output wire wait_n,
	output logic [7:0] last_wr
);
	logic [3:0] low_cnt = 4'h0;
	logic flip = 1'b0;
	// strobe age, write capture, idle pattern
	always @(posedge mclk) begin
		low_cnt <= (read_strobe_n && data_put_strobe_n) ? 4'h0 : low_cnt + 4'h1;
		if (!data_put_strobe_n) last_wr <= data_out;
		flip <= ~flip;
	end
	// read data only while selected, else a toggling pattern
	assign data_in = !read_strobe_n ? (addr_out[7:0] ^ 8'h5a) : {8{flip}};
	// slow device holds wait low until stall strobe cycles have passed;
	// low already before the strobe so the two-stage pin sync sees it in phase_two
	assign wait_n = low_cnt >= stall;
endmodule // bus_partner_model

// ===== tb/tb_cpu_external_bus_cycle_sequencer.sv
`timescale 1ns/100ps
// ****************************************
// bench
// ****************************************
module tb_cpu_external_bus_cycle_sequencer;
	logic mclk, rst_n, req_valid, req_port_internal, req_force_indicator, fetch_indicator_enable;
	logic port_timing_compat, reset_pin_n, bus_request_n;
	logic [2:0] req_kind;
	logic [19:0] req_addr, addr_out, seen_addr;
	logic [7:0] req_wdata, rdata, data_out, last_wr;
	logic [1:0] mem_wait_count, io_wait_count;
	logic [3:0] stall;
	wire [7:0] data_in;
	wire wait_n, req_ready, done, restart, bus_grant_n, addr_oe, data_oe, strobe_oe;
	wire storage_strobe_n, port_strobe_n, read_strobe_n, data_put_strobe_n, opcode_fetch_strobe_n;
	wire phi;
	int err_total = 0, compares = 0, cyc_cnt = 0;
	bus_cycle_seq u_dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_kind(req_kind),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_port_internal(req_port_internal),
		.req_force_indicator(req_force_indicator), .req_ready(req_ready), .done(done),
		.rdata(rdata), .restart(restart), .fetch_indicator_enable(fetch_indicator_enable),
		.port_timing_compat(port_timing_compat), .mem_wait_count(mem_wait_count),
		.io_wait_count(io_wait_count), .phi(phi), .reset_pin_n(reset_pin_n), .wait_n(wait_n),
		.bus_request_n(bus_request_n), .bus_grant_n(bus_grant_n), .addr_out(addr_out),
		.addr_oe(addr_oe), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.storage_strobe_n(storage_strobe_n), .port_strobe_n(port_strobe_n),
		.read_strobe_n(read_strobe_n), .data_put_strobe_n(data_put_strobe_n),
		.strobe_oe(strobe_oe), .opcode_fetch_strobe_n(opcode_fetch_strobe_n));
	bus_partner_model u_mem (.mclk(mclk), .addr_out(addr_out), .read_strobe_n(read_strobe_n),
		.data_put_strobe_n(data_put_strobe_n), .data_out(data_out), .stall(stall),
		.data_in(data_in), .wait_n(wait_n), .last_wr(last_wr));
	// clock and hang limit
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			err_total++;
			end_of_test();
		end
	end
	task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one machine cycle, n counts clocks from take to done
	task automatic cyc(input logic [2:0] k, input logic [19:0] a, input logic [7:0] w,
		input logic pi, output int n, output logic ofl);
		int t;
		req_kind = k;
		req_addr = a;
		req_wdata = w;
		req_port_internal = pi;
		req_valid = 1'b1;
		t = 0;
		do begin @(posedge mclk); t++; end while (req_ready !== 1'b1 && t < 300);
		#1 req_valid = 1'b0;
		seen_addr = addr_out;
		n = 0;
		ofl = 1'b1;
		do begin
			@(posedge mclk);
			n++;
			if (opcode_fetch_strobe_n === 1'b0) ofl = 1'b0;
		end while (done !== 1'b1 && n < 300);
		#1;
	endtask
	task automatic t_fetch;
		int n;
		logic ofl;
		for (int m = 0; m < 4; m++) begin
			fetch_indicator_enable = m[0];
			req_force_indicator = m[1];
			cyc(3'h0, 20'h1a3c0 + m, 8'h00, 1'b0, n, ofl);
			chk("fetch_len", 7, n);
			chk("fetch_addr", m ? 20'h1a3c0 + m : 20'h00000, seen_addr);
			chk("fetch_data", (m ? 8'hc0 + m : 8'h00) ^ 8'h5a, rdata);
			chk("fetch_ind", !(m[0] | m[1]), ofl);
		end
		fetch_indicator_enable = 1'b1;
		$display("test fetch done");
	endtask
	task automatic t_mem;
		int n;
		logic ofl;
		mem_wait_count = 2'h2;
		cyc(3'h1, 20'h30455, 8'h00, 1'b0, n, ofl);
		chk("read_len", 11, n);
		chk("read_data", 8'h55 ^ 8'h5a, rdata);
		mem_wait_count = 2'h0;
		cyc(3'h2, 20'h00777, 8'ha5, 1'b0, n, ofl);
		chk("write_len", 7, n);
		chk("write_data", 8'ha5, last_wr);
		stall = 4'h6;
		cyc(3'h0, 20'h00012, 8'h00, 1'b0, n, ofl);
		chk("wait_len", 15, n);
		stall = 4'h0;
		cyc(3'h5, 20'h00001, 8'h00, 1'b0, n, ofl);
		chk("idle_len", 3, n);
		$display("test memory done");
	endtask
	task automatic t_io;
		int n;
		logic ofl;
		for (int m = 0; m < 8; m++) begin
			port_timing_compat = m[0];
			cyc(m[1] ? 3'h4 : 3'h3, 20'hf2b00 + m, 8'h3c, m[2], n, ofl);
			chk("io_len", m[2] ? 7 : 9, n);
			if (!m[1]) chk("io_data", m[7:0] ^ 8'h5a, rdata);
		end
		$display("test port done");
	endtask
	task automatic t_misc;
		int n;
		logic ofl, g, r;
		g = phi;
		@(posedge mclk);
		#1 chk("phi_toggle", !g, phi);
		bus_request_n = 1'b0;
		g = 1'b0;
		repeat (10) begin @(posedge mclk); if (bus_grant_n === 1'b0) g = 1'b1; end
		#1 bus_request_n = 1'b1;
		chk("grant_low", 1, g);
		for (int m = 0; m < 2; m++) begin
			reset_pin_n = 1'b0;
			repeat (m ? 16 : 6) @(posedge mclk);
			#1 reset_pin_n = 1'b1;
			r = 1'b0;
			repeat (12) begin @(posedge mclk); if (restart === 1'b1) r = 1'b1; end
			#1 chk("restart", m, r);
		end
		cyc(3'h0, 20'h0abcd, 8'h00, 1'b0, n, ofl);
		chk("restart_addr", 20'h00000, seen_addr);
		$display("test exchange and reset done");
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// main sequence
	initial begin
		{rst_n, req_valid, req_port_internal, req_force_indicator, port_timing_compat} = 5'h00;
		{fetch_indicator_enable, reset_pin_n, bus_request_n} = 3'h7;
		{req_kind, req_addr, req_wdata, mem_wait_count, io_wait_count, stall} = '0;
		repeat (2) @(posedge mclk);
		#1 rst_n = 1'b1;
		t_fetch();
		t_mem();
		t_io();
		t_misc();
		end_of_test();
	end
endmodule // tb_cpu_external_bus_cycle_sequencer
